// ==== core/sensor_hub_param_readout.sv ====
// Read-only system parameter readout of the sensor hub: timestamps, status, presence, info
//
// Function
// - Timestamp parameter: last interrupt and now
// - Interrupt time: 32 bits, LSB first, 32 kHz
// - Current time in bytes 4-7, read-only
// - Interrupt time also in registers 0x6C-0x6F
// - Status record: accelerometer rate, range, flags
// - Status record: gyroscope at bytes 5-9
// - Status record: magnetometer at bytes 10-14
// - Flags: irq enable bit 0, mode bits 5-7
// - Power mode codes zero to seven defined
// - 64-bit bitmap, bit per present sensor
// - Bitmap bit 0 of byte 0 upward
// - Parameters 33-96 return present sensor's info
// - Absent sensor: info record all zeros
// - Info byte 0: parameter number minus 32
// - Info bytes 1-2: driver id, version
// - Info bytes 4-5: dynamic range, 16 bit
// - Info byte 6 flags; byte 7 reserved
// - Info bytes 8-9: sample rate in hertz
// - Info byte 10: number of axes
// - Info bytes 11-15: matrix nibbles, in order
`timescale 1ns/10ps
module sensor_hub_param_readout
   import sensor_hub_pkg::*;
#(
   // Cycles per 32 kHz tick; shorten for simulation
   parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   // Host interrupt raised, one-cycle pulse
   input wire logic host_irq_evt,
   // Parameter read request and answer
   input wire logic param_rd_req,
   input wire logic [6:0] param_num,
   output logic param_rd_done,
   output logic param_rd_err,
   output logic [4:0] param_len,
   output param_buf_t param_buf,
   // Direct register read port
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   output logic reg_rd_valid,
   output logic [7:0] reg_rdata,
   // Live sensor state from the hub's own logic
   input wire phys_status_t phys_status,
   input wire logic [63:0] present_map,
   // Descriptor lookup for the information record
   output logic [6:0] info_sel_id,
   input wire info_attr_t info_attr,
   // Running system time
   output logic [31:0] now_time
);

   // Request sequencer states, Gray along idle, fetch, done
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_DONE = 2'b11
   } rd_state_t;

   rd_state_t state_ff; // Sequencer state
   rd_state_t nxt_state; // Next sequencer state
   logic [15:0] cyc_ff; // Prescaler toward one tick
   logic [31:0] now_ff; // Present system time in ticks
   logic [31:0] irq_ts_ff; // Time of the last host interrupt
   logic [6:0] req_num_ff; // Parameter number being served
   logic [6:0] sel_id_ff; // Physical sensor id of the request
   param_buf_t buf_ff; // Assembled record
   logic [4:0] len_ff; // Valid bytes in the record
   logic err_ff; // Unknown parameter flag
   logic [7:0] rdata_ff; // Direct register read data
   logic rvalid_ff; // Direct register read answer
   logic tick_wrap; // Prescaler at its last cycle
   logic is_info; // Request falls in the info range
   logic present_hit; // Addressed sensor is fitted
   param_buf_t info_rec; // Packed information record
   param_buf_t status_rec; // Packed physical status record
   param_buf_t ts_rec; // Packed timestamp record

   // Range test used for both the decode and the checks
   function automatic logic in_info_range(input logic [6:0] num);
      return (num >= PARAM_INFO_FIRST) && (num <= PARAM_INFO_LAST);
   endfunction

   // Prescaler wraps on the same edge that advances the tick
   assign tick_wrap = (cyc_ff == 16'(TICK_CYCLES_P - 1));

   // Prescaler: divides the system clock down to the 32 kHz tick
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cyc_ff <= 16'h0000;
      end
      else if (tick_wrap)
      begin
         cyc_ff <= 16'h0000;
      end
      else
      begin
         cyc_ff <= cyc_ff + 16'h0001;
      end
   end

   // System time counts ticks; wraps silently after 2^32 ticks
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         now_ff <= RST_TIME;
      end
      else if (tick_wrap)
      begin
         now_ff <= now_ff + 32'h0000_0001;
      end
   end

   // Snapshot of time at each host interrupt; old time wins on a tick edge
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_ts_ff <= RST_TIME;
      end
      else if (host_irq_evt)
      begin
         irq_ts_ff <= now_ff;
      end
   end

   assign now_time = now_ff;

   // Sequencer: one request in flight, others ignored while busy
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE:
         begin
            if (param_rd_req)
            begin
               nxt_state = ST_FETCH;
            end
         end
         ST_FETCH:
         begin
            nxt_state = ST_DONE;
         end
         ST_DONE:
         begin
            nxt_state = ST_IDLE;
         end
         default:
         begin
            // Illegal code 2'b10 recovers to idle
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Sequencer state register
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff <= ST_IDLE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Request capture; sensor id is the parameter number less the bias
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         req_num_ff <= 7'h00;
         sel_id_ff <= 7'h00;
      end
      else if ((state_ff == ST_IDLE) && param_rd_req)
      begin
         req_num_ff <= param_num;
         sel_id_ff <= 7'(param_num - INFO_TYPE_BIAS);
      end
   end

   // Lookup index stands from capture until the next request
   assign info_sel_id = sel_id_ff;
   assign is_info = in_info_range(req_num_ff);
   // Id 64 has no bitmap bit and reads as absent
   assign present_hit = is_info && (sel_id_ff[6] == 1'b0) && present_map[sel_id_ff[5:0]];

   // Information record packer
   sensor_info_packer sensor_info_packer_i (
      .param_num (req_num_ff),
      .present (present_hit),
      .attr (info_attr),
      .record (info_rec)
   );

   // Timestamp record: interrupt time then present time, low byte first
   always_comb
   begin
      ts_rec = '0;
      for (int b = 0; b < 4; b++)
      begin
         ts_rec[TS_IRQ_BYTE + b] = irq_ts_ff[8 * b +: 8];
         ts_rec[TS_NOW_BYTE + b] = now_ff[8 * b +: 8];
      end
   end

   // Physical status record: three groups of rate, range, flags
   always_comb
   begin
      status_rec = '0;
      status_rec[ST_ACC_BYTE + ST_RATE_OFS] = phys_status.accel.rate_hz[7:0];
      status_rec[ST_ACC_BYTE + ST_RATE_OFS + 1] = phys_status.accel.rate_hz[15:8];
      status_rec[ST_ACC_BYTE + ST_RANGE_OFS] = phys_status.accel.range[7:0];
      status_rec[ST_ACC_BYTE + ST_RANGE_OFS + 1] = phys_status.accel.range[15:8];
      status_rec[ST_ACC_BYTE + ST_FLAGS_OFS] = flags_byte(phys_status.accel.irq_en, phys_status.accel.mode);
      status_rec[ST_GYR_BYTE + ST_RATE_OFS] = phys_status.gyro.rate_hz[7:0];
      status_rec[ST_GYR_BYTE + ST_RATE_OFS + 1] = phys_status.gyro.rate_hz[15:8];
      status_rec[ST_GYR_BYTE + ST_RANGE_OFS] = phys_status.gyro.range[7:0];
      status_rec[ST_GYR_BYTE + ST_RANGE_OFS + 1] = phys_status.gyro.range[15:8];
      status_rec[ST_GYR_BYTE + ST_FLAGS_OFS] = flags_byte(phys_status.gyro.irq_en, phys_status.gyro.mode);
      status_rec[ST_MAG_BYTE + ST_RATE_OFS] = phys_status.mag.rate_hz[7:0];
      status_rec[ST_MAG_BYTE + ST_RATE_OFS + 1] = phys_status.mag.rate_hz[15:8];
      status_rec[ST_MAG_BYTE + ST_RANGE_OFS] = phys_status.mag.range[7:0];
      status_rec[ST_MAG_BYTE + ST_RANGE_OFS + 1] = phys_status.mag.range[15:8];
      status_rec[ST_MAG_BYTE + ST_FLAGS_OFS] = flags_byte(phys_status.mag.irq_en, phys_status.mag.mode);
   end

   // Record load in the fetch cycle; buffer holds until the next fetch
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         buf_ff <= '0;
         len_ff <= LEN_NONE;
         err_ff <= 1'b0;
      end
      else if (state_ff == ST_FETCH)
      begin
         err_ff <= 1'b0;
         if (req_num_ff == PARAM_TIMESTAMP)
         begin
            buf_ff <= ts_rec;
            len_ff <= LEN_TIMESTAMP;
         end
         else if (req_num_ff == PARAM_PHYS_STATUS)
         begin
            buf_ff <= status_rec;
            len_ff <= LEN_STATUS;
         end
         else if (req_num_ff == PARAM_PHYS_PRESENT)
         begin
            // Bit n of the map is bit n%8 of byte n/8
            buf_ff <= {64'h0, present_map};
            len_ff <= LEN_PRESENT;
         end
         else if (is_info)
         begin
            buf_ff <= info_rec;
            len_ff <= LEN_INFO;
         end
         else
         begin
            // Not a parameter of this block: empty answer, error flagged
            buf_ff <= '0;
            len_ff <= LEN_NONE;
            err_ff <= 1'b1;
         end
      end
   end

   assign param_rd_done = (state_ff == ST_DONE);
   assign param_rd_err = err_ff;
   assign param_len = len_ff;
   assign param_buf = buf_ff;

   // Direct register read: one byte of the interrupt time, next cycle
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_ff <= RST_RDATA;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rvalid_ff <= reg_rd_en;
         if (reg_rd_en && (reg_addr >= REG_IRQ_TS_FIRST) && (reg_addr <= REG_IRQ_TS_LAST))
         begin
            rdata_ff <= irq_ts_ff[8 * reg_addr[1:0] +: 8];
         end
         else if (reg_rd_en)
         begin
            // Any other address reads zero
            rdata_ff <= RST_RDATA;
         end
      end
   end

   assign reg_rd_valid = rvalid_ff;
   assign reg_rdata = rdata_ff;

   // Checks on this block's own registers and outputs
   default clocking chk_cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   chk_irq_capture: assert property (host_irq_evt |=> irq_ts_ff == $past(now_ff))
      else $error("interrupt time not captured");

   chk_tick_rate: assert property ($changed(now_ff) |-> $past(cyc_ff) == 16'(TICK_CYCLES_P - 1))
      else $error("time advanced off the tick");

   chk_ts_irq_bytes: assert property ((param_rd_done && req_num_ff == PARAM_TIMESTAMP)
      |-> {param_buf[3], param_buf[2], param_buf[1], param_buf[0]} == $past(irq_ts_ff))
      else $error("interrupt time bytes wrong");

   chk_ts_now_bytes: assert property ((param_rd_done && req_num_ff == PARAM_TIMESTAMP)
      |-> {param_buf[7], param_buf[6], param_buf[5], param_buf[4]} == $past(now_ff))
      else $error("current time bytes wrong");

   chk_reg_low_byte: assert property ((reg_rd_en && reg_addr == REG_IRQ_TS_FIRST)
      |=> reg_rd_valid && reg_rdata == $past(irq_ts_ff[7:0]))
      else $error("register low byte wrong");

   chk_status_flags: assert property ((param_rd_done && req_num_ff == PARAM_PHYS_STATUS)
      |-> param_buf[9][0] == $past(phys_status.gyro.irq_en)
      && param_buf[14][7:5] == $past(phys_status.mag.mode) && param_buf[4][4:1] == 4'h0)
      else $error("status flags byte wrong");

   chk_present_map: assert property ((param_rd_done && req_num_ff == PARAM_PHYS_PRESENT)
      |-> param_buf[7:0] == $past(present_map))
      else $error("presence bitmap wrong");

   chk_absent_zero: assert property ((state_ff == ST_FETCH && is_info && !present_hit)
      |=> param_buf == '0 && param_len == LEN_INFO)
      else $error("absent sensor record not zero");

   chk_info_type: assert property ((state_ff == ST_FETCH && present_hit)
      |=> param_buf[0] == {1'b0, 7'(req_num_ff - INFO_TYPE_BIAS)})
      else $error("sensor type byte wrong");

   chk_done_latency: assert property ((state_ff == ST_IDLE && param_rd_req)
      |-> ##1 !param_rd_done ##1 param_rd_done ##1 !param_rd_done)
      else $error("read answer not two cycles after request");

endmodule

// ==== pkg/sensor_hub_pkg.sv ====
// Shared constants, record layouts and types for the sensor hub parameter readout
package sensor_hub_pkg;

   // Time base: system clock and the 32 kHz timestamp tick
   localparam int unsigned SYS_CLK_HZ = 200_000_000;
   localparam int unsigned TICK_HZ = 32_000;
   // Cycles per tick, rounded down (exact at these rates)
   localparam int unsigned TICK_CYCLES = SYS_CLK_HZ / TICK_HZ;
   localparam logic [31:0] RST_TIME = 32'h0000_0000;

   // Parameter numbers served by the readout
   localparam logic [6:0] PARAM_TIMESTAMP = 7'h1E;
   localparam logic [6:0] PARAM_PHYS_STATUS = 7'h1F;
   localparam logic [6:0] PARAM_PHYS_PRESENT = 7'h20;
   localparam logic [6:0] PARAM_INFO_FIRST = 7'h21;
   localparam logic [6:0] PARAM_INFO_LAST = 7'h60;
   localparam logic [6:0] INFO_TYPE_BIAS = 7'h20;

   // Direct registers holding the last host interrupt time
   localparam logic [7:0] REG_IRQ_TS_FIRST = 8'h6C;
   localparam logic [7:0] REG_IRQ_TS_LAST = 8'h6F;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // Valid byte counts of each record
   localparam logic [4:0] LEN_NONE = 5'h00;
   localparam logic [4:0] LEN_TIMESTAMP = 5'h08;
   localparam logic [4:0] LEN_STATUS = 5'h0F;
   localparam logic [4:0] LEN_PRESENT = 5'h08;
   localparam logic [4:0] LEN_INFO = 5'h10;

   // Flags byte fields
   localparam int unsigned FLAG_IRQ_BIT = 0;
   localparam int unsigned FLAG_MODE_LSB = 5;

   // Timestamp record byte positions
   localparam int unsigned TS_IRQ_BYTE = 0;
   localparam int unsigned TS_NOW_BYTE = 4;

   // Status record: sensor base bytes and offsets inside each group
   localparam int unsigned ST_ACC_BYTE = 0;
   localparam int unsigned ST_GYR_BYTE = 5;
   localparam int unsigned ST_MAG_BYTE = 10;
   localparam int unsigned ST_RATE_OFS = 0;
   localparam int unsigned ST_RANGE_OFS = 2;
   localparam int unsigned ST_FLAGS_OFS = 4;

   // Information record byte positions
   localparam int unsigned INF_TYPE_BYTE = 0;
   localparam int unsigned INF_DRV_ID_BYTE = 1;
   localparam int unsigned INF_DRV_VER_BYTE = 2;
   localparam int unsigned INF_CURRENT_BYTE = 3;
   localparam int unsigned INF_RANGE_BYTE = 4;
   localparam int unsigned INF_FLAGS_BYTE = 6;
   localparam int unsigned INF_RATE_BYTE = 8;
   localparam int unsigned INF_AXES_BYTE = 10;
   localparam int unsigned INF_MATRIX_BYTE = 11;
   localparam int unsigned MATRIX_ELEMS = 9;

   // Sensor power mode codes
   typedef enum logic [2:0] {
      PWR_ABSENT = 3'h0,
      PWR_DOWN = 3'h1,
      PWR_SUSPEND = 3'h2,
      PWR_SELF_TEST = 3'h3,
      PWR_MOTION_IRQ = 3'h4,
      PWR_ONE_SHOT = 3'h5,
      PWR_LOW_POWER = 3'h6,
      PWR_ACTIVE = 3'h7
   } pwr_mode_t;

   // One physical sensor's live settings
   typedef struct packed {
      logic [15:0] rate_hz;
      logic [15:0] range;
      logic irq_en;
      pwr_mode_t mode;
   } sensor_stat_t;

   // The three core physical sensors
   typedef struct packed {
      sensor_stat_t accel;
      sensor_stat_t gyro;
      sensor_stat_t mag;
   } phys_status_t;

   // Descriptor of one physical sensor for the information record
   typedef struct packed {
      logic [7:0] driver_id;
      logic [7:0] driver_ver;
      logic [7:0] current;
      logic [15:0] range;
      logic irq_en;
      pwr_mode_t mode;
      logic [15:0] rate_hz;
      logic [7:0] axes;
      logic [MATRIX_ELEMS-1:0][3:0] matrix;
   } info_attr_t;

   // Sixteen-byte read buffer, byte 0 in the low lane
   typedef logic [15:0][7:0] param_buf_t;

   // Flags byte: interrupt enable low, power mode on top, middle reserved
   function automatic logic [7:0] flags_byte(input logic irq_en, input pwr_mode_t mode);
      logic [7:0] f;
      f = 8'h00;
      f[FLAG_IRQ_BIT] = irq_en;
      f[FLAG_MODE_LSB +: 3] = mode;
      return f;
   endfunction

endpackage

// ==== core/sensor_info_packer.sv ====
// Packs one physical sensor descriptor into the sixteen-byte information record
`timescale 1ns/10ps
module sensor_info_packer
   import sensor_hub_pkg::*;
(
   input wire logic [6:0] param_num,
   input wire logic present,
   input wire info_attr_t attr,
   output param_buf_t record
);

   // Record built from the descriptor and parameter number; zero when the sensor is absent
   always_comb
   begin
      record = '0;
      if (present)
      begin
         record[INF_TYPE_BYTE] = {1'b0, 7'(param_num - INFO_TYPE_BIAS)};
         record[INF_DRV_ID_BYTE] = attr.driver_id;
         record[INF_DRV_VER_BYTE] = attr.driver_ver;
         record[INF_CURRENT_BYTE] = attr.current;
         // Low byte at the lower index
         record[INF_RANGE_BYTE] = attr.range[7:0];
         record[INF_RANGE_BYTE + 1] = attr.range[15:8];
         // Reserved bits 1-4 stay zero; byte 7 reserved
         record[INF_FLAGS_BYTE] = flags_byte(attr.irq_en, attr.mode);
         record[INF_RATE_BYTE] = attr.rate_hz[7:0];
         record[INF_RATE_BYTE + 1] = attr.rate_hz[15:8];
         record[INF_AXES_BYTE] = attr.axes;
         // Element n lands in nibble n, low nibble of a byte first
         for (int i = 0; i < MATRIX_ELEMS; i++)
         begin
            record[INF_MATRIX_BYTE + i / 2][4 * (i % 2) +: 4] = attr.matrix[i];
         end
      end
      // Absent sensor leaves every byte zero
   end

endmodule

// ==== tb/host_reader_model.sv ====
// Host processor model that issues parameter reads and direct register reads
`timescale 1ns/10ps
module host_reader_model
(
   input wire logic sys_clk,
   input wire logic param_rd_done,
   input wire logic reg_rd_valid,
   input wire logic [7:0] reg_rdata,
   output logic param_rd_req,
   output logic [6:0] param_num,
   output logic reg_rd_en,
   output logic [7:0] reg_addr
);
   // Bus idle from time zero
   initial
   begin
      param_rd_req = 1'b0;
      param_num = 7'h00;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
   end

   // One parameter read; ok stays low if the answer strobe never shows
   task automatic param_read(input logic [6:0] num, output logic ok);
      int n;
      ok = 1'b0;
      @(posedge sys_clk);
      #1;
      param_rd_req = 1'b1;
      param_num = num;
      // Taken at this edge, the block being idle
      @(posedge sys_clk);
      #1;
      param_rd_req = 1'b0;
      // Bounded wait, the strobe lasts a single cycle
      for (n = 0; n < 6 && ok == 1'b0; n++)
      begin
         if (param_rd_done === 1'b1)
            ok = 1'b1;
         else
         begin
            @(posedge sys_clk);
            #1;
         end
      end
   endtask

   // One direct register read, answered one cycle later
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(posedge sys_clk);
      #1;
      reg_rd_en = 1'b1;
      reg_addr = addr;
      @(posedge sys_clk);
      #1;
      reg_rd_en = 1'b0;
      ok = reg_rd_valid;
      data = reg_rdata;
   endtask
endmodule

// ==== tb/sensor_hub_param_readout_tb.sv ====
// Self-checking bench for the sensor hub parameter readout
`timescale 1ns/10ps
module sensor_hub_param_readout_tb
   import sensor_hub_pkg::*;
;
   localparam int unsigned TICKS = 4; // Short tick keeps the run brief
   logic sys_clk, arst_n, host_irq_evt;
   logic param_rd_req, param_rd_done, param_rd_err;
   logic [6:0] param_num, info_sel_id;
   logic [4:0] param_len;
   param_buf_t param_buf;
   logic reg_rd_en, reg_rd_valid;
   logic [7:0] reg_addr, reg_rdata;
   phys_status_t phys_status;
   logic [63:0] present_map;
   info_attr_t info_attr;
   logic [31:0] now_time, irq_t, t;
   int errors, num_checks;
   int cycles = 0;

   sensor_hub_param_readout #(.TICK_CYCLES_P(TICKS)) sensor_hub_param_readout_i (.sys_clk(sys_clk),
      .arst_n(arst_n), .host_irq_evt(host_irq_evt), .param_rd_req(param_rd_req), .param_num(param_num),
      .param_rd_done(param_rd_done), .param_rd_err(param_rd_err), .param_len(param_len),
      .param_buf(param_buf), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rd_valid(reg_rd_valid),
      .reg_rdata(reg_rdata), .phys_status(phys_status), .present_map(present_map),
      .info_sel_id(info_sel_id), .info_attr(info_attr), .now_time(now_time));

   host_reader_model host_reader_model_i (.sys_clk(sys_clk), .param_rd_done(param_rd_done),
      .reg_rd_valid(reg_rd_valid), .reg_rdata(reg_rdata), .param_rd_req(param_rd_req),
      .param_num(param_num), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr));

   // Descriptor of each sensor id; matrix elements 0, 4 and 8 set
   function automatic info_attr_t mk_attr(input logic [6:0] id);
      info_attr_t a;
      a.driver_id = 8'h40 + {1'b0, id};
      a.driver_ver = 8'h11;
      a.current = 8'h22;
      a.range = 16'h1230 + {9'h000, id};
      a.irq_en = id[0];
      a.mode = pwr_mode_t'(id[2:0]);
      a.rate_hz = 16'h0190;
      a.axes = 8'h03;
      a.matrix = 36'hF000F0001;
      return a;
   endfunction

   // Lookup answers combinationally, well inside the fetch cycle
   always_comb info_attr = mk_attr(info_sel_id);

   // Clock at 200 MHz
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         $display("Error timeout expected end of tests seen %0d cycles", cycles);
         stop_test();
      end
   end

   // One comparison, reported at once on mismatch
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Parameter read plus answer-strobe check
   task automatic pread(input logic [6:0] num);
      logic ok;
      host_reader_model_i.param_read(num, ok);
      chk("param_rd_done", 128'h1, {127'h0, ok});
   endtask

   // Direct register read with expected byte
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host_reader_model_i.reg_read(a, d, ok);
      chk("reg_rd_valid", 128'h1, {127'h0, ok});
      chk("reg_rdata", {120'h0, exp}, {120'h0, d});
   endtask

   // Verdict and end of run
   task automatic stop_test();
      $display("Checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      sensor_stat_t s[3];
      param_buf_t b;
      logic [6:0] nums[6];
      logic [6:0] bad[4];
      logic [6:0] id;
      errors = 0;
      num_checks = 0;
      arst_n = 1'b0;
      host_irq_evt = 1'b0;
      phys_status = '0;
      present_map = 64'h8000_0000_0000_1006; // Ids 1, 2, 12 and 63 fitted
      repeat (8) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      chk("now_time", 128'h0, {96'h0, now_time});
      chk("param_buf", 128'h0, param_buf);
      // Raise the host interrupt mid-run; pre-edge time is stored
      repeat (9) @(posedge sys_clk);
      #1;
      // Ticks since release: one per TICKS edges, release at edge 8
      irq_t = 32'((cycles - 8) / TICKS);
      host_irq_evt = 1'b1;
      @(posedge sys_clk);
      #1;
      host_irq_evt = 1'b0;
      repeat (10) @(posedge sys_clk);
      pread(PARAM_TIMESTAMP);
      chk("ts irq", {96'h0, irq_t}, {96'h0, param_buf[3:0]});
      // Snapshot is the time of the fetch cycle, one edge before now
      chk("ts now", {96'h0, 32'((cycles - 9) / TICKS)}, {96'h0, param_buf[7:4]});
      chk("ts len", {123'h0, LEN_TIMESTAMP}, {123'h0, param_len});
      chk("ts err", 128'h0, {127'h0, param_rd_err});
      // Time base advances once per tick
      t = now_time;
      repeat (4 * TICKS) @(posedge sys_clk);
      #1;
      chk("tick", {96'h0, t + 32'h4}, {96'h0, now_time});
      for (int i = 0; i < 4; i++)
         rreg(8'h6C + 8'(i), irq_t[8*i +: 8]);
      rreg(8'h6B, 8'h00);
      rreg(8'h70, 8'h00);
      // Every power mode code on each sensor group
      for (int m = 0; m < 8; m++)
      begin
         s[0] = '{16'h0064 + 16'(m), 16'h0010, m[0], pwr_mode_t'(m)};
         s[1] = '{16'h0C80, 16'h07D0 + 16'(m), ~m[0], pwr_mode_t'(7 - m)};
         s[2] = '{16'h0019, 16'h04B0, m[1], pwr_mode_t'(m ^ 3)};
         phys_status = {s[0], s[1], s[2]};
         b = '0;
         for (int k = 0; k < 3; k++)
         begin
            b[5*k] = s[k].rate_hz[7:0];
            b[5*k+1] = s[k].rate_hz[15:8];
            b[5*k+2] = s[k].range[7:0];
            b[5*k+3] = s[k].range[15:8];
            b[5*k+4] = {s[k].mode, 4'h0, s[k].irq_en};
         end
         pread(PARAM_PHYS_STATUS);
         chk("status", b, param_buf);
         chk("status len", {123'h0, LEN_STATUS}, {123'h0, param_len});
      end
      // Presence bitmap, byte by byte
      b = '0;
      b[0] = 8'h06;
      b[1] = 8'h10;
      b[7] = 8'h80;
      pread(PARAM_PHYS_PRESENT);
      chk("present", b, param_buf);
      // Fitted, absent and edge parameter numbers
      nums = '{7'h21, 7'h22, 7'h2C, 7'h23, 7'h5F, 7'h60};
      foreach (nums[n])
      begin
         id = nums[n] - 7'h20;
         b = '0;
         if (id < 7'h40 && present_map[id[5:0]] === 1'b1)
         begin
            info_attr_t a;
            a = mk_attr(id);
            b[0] = {1'b0, id};
            b[1] = a.driver_id;
            b[2] = a.driver_ver;
            b[3] = a.current;
            b[4] = a.range[7:0];
            b[5] = a.range[15:8];
            b[6] = {a.mode, 4'h0, a.irq_en};
            b[8] = a.rate_hz[7:0];
            b[9] = a.rate_hz[15:8];
            b[10] = a.axes;
            b[11] = 8'h01;
            b[13] = 8'h0F;
            b[15] = 8'h0F;
         end
         pread(nums[n]);
         chk("info", b, param_buf);
         chk("info len", {123'h0, LEN_INFO}, {123'h0, param_len});
         chk("info err", 128'h0, {127'h0, param_rd_err});
      end
      // Parameter numbers outside the served set
      bad = '{7'h05, 7'h61, 7'h7F, 7'h1D};
      foreach (bad[n])
      begin
         pread(bad[n]);
         chk("bad err", 128'h1, {127'h0, param_rd_err});
         chk("bad len", 128'h0, {123'h0, param_len});
         chk("bad buf", 128'h0, param_buf);
      end
      stop_test();
   end
endmodule
